// file: design/mbs_params.svh
// Constants of the motor brake sequencer: register offsets, fields, resets, limits, timing.
// Assumes a 125 MHz mclk; frequencies in 0.01 Hz, current in 0.1 %, delays in 10 ms units.
`ifndef MBS_PARAMS_SVH
`define MBS_PARAMS_SVH

`define MBS_ADDR_W 5
`define MBS_OFS_CTRL 5'h00
`define MBS_OFS_REL_FREQ 5'h04
`define MBS_OFS_ENGAGE 5'h08
`define MBS_OFS_RELEASE 5'h0c
`define MBS_OFS_DC_STOP 5'h10
`define MBS_OFS_STATUS 5'h14

`define MBS_CTRL_EN_BIT 0
`define MBS_CTRL_MODE_LSB 1
`define MBS_CTRL_TORQUE_BIT 4
`define MBS_CTRL_SEL_LSB 8
`define MBS_MODE_VECTOR 3'h5

`define MBS_RST_CTRL 32'h0000_0000
`define MBS_RST_REL_FREQ 32'h0064_0064
`define MBS_RST_ENGAGE 32'h0064_00c8
`define MBS_RST_RELEASE 32'h0064_01f4
`define MBS_RST_DC_STOP 32'h0000_0000

`define MBS_FREQ_MAX 16'h9c40
`define MBS_CURR_MAX 16'h0708
`define MBS_DELAY_MAX 16'h03e8

`define MBS_CLK_MHZ 125
`define MBS_DELAY_UNIT_US 10000
`define MBS_UNIT_CYCLES (`MBS_DELAY_UNIT_US * `MBS_CLK_MHZ)

`endif

// file: design/mbs_pkg.sv
// Types shared by the motor brake sequencer files.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package mbs_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_WAIT_REL = 3'h1,
        ST_REL_HOLD = 3'h2,
        ST_RUN = 3'h3,
        ST_DECEL = 3'h4,
        ST_ENG_HOLD = 3'h5,
        ST_DC_INJ = 3'h6
    } mbs_state_type;

    typedef struct packed {
        mbs_state_type st;
        logic [31:0] ctrl;
        logic [31:0] rel_freq;
        logic [31:0] engage;
        logic [31:0] release_cfg;
        logic [31:0] dc_stop;
        logic [31:0] rdata;
        logic wait_req;
        logic rev;
        logic brake_release;
        logic override;
        logic hold;
        logic dc_inject;
        logic block;
        logic suppress;
        logic tstart;
        logic [15:0] fref;
        logic [2:0] relay;
    } mbs_seq_state_type;

endpackage

`default_nettype wire

// file: design/mbs_hold_timer.sv
// Delay timer counting whole delay units after a start pulse.
// Assumes start is one cycle long and length stays stable while it is high.
`timescale 1ns/10ps
`default_nettype none
`include "mbs_params.svh"

module mbs_hold_timer #(
    parameter int UNIT_CYCLES = `MBS_UNIT_CYCLES,
    parameter int LEN_W = 16
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [LEN_W-1:0] length,
    output logic done
);
    localparam int PW = $clog2(UNIT_CYCLES) + 1;
    localparam logic [PW-1:0] PRE_TOP = PW'(UNIT_CYCLES - 1);

    typedef struct packed {
        logic busy;
        logic done;
        logic [LEN_W-1:0] units;
        logic [PW-1:0] pre;
    } mbs_tmr_state_type;

    mbs_tmr_state_type q;
    mbs_tmr_state_type d;

    if (UNIT_CYCLES < 1 || LEN_W < 1) begin : g_check
        $error("mbs_hold_timer: unit length and width must be at least one");
    end

    // Done rises once the full number of units has passed and stays until the next start.
    always_comb begin
        d = q;
        if (start) begin
            d.busy = 1'b1;
            d.done = 1'b0;
            d.units = length;
            d.pre = PRE_TOP;
        end else if (q.busy) begin
            if (q.units == '0) begin
                d.busy = 1'b0;
                d.done = 1'b1;
            end else if (q.pre == '0) begin
                d.pre = PRE_TOP;
                d.units = q.units - 1'b1;
            end else begin
                d.pre = q.pre - 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign done = q.done;

endmodule // mbs_hold_timer

`default_nettype wire

// file: design/mbs_brake_sequencer.sv
// Brake sequencer top: Avalon-MM register slave, brake release/engage state machine, outputs.
// Assumes drive inputs synchronous to mclk; frequency 0.01 Hz, current 0.1 % units.
//
// The implementer's own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "mbs_params.svh"

module mbs_brake_sequencer #(
    parameter int UNIT_CYCLES = `MBS_UNIT_CYCLES
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [`MBS_ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic run_cmd,
    input wire logic reverse_cmd,
    input wire logic [15:0] out_freq,
    input wire logic [15:0] motor_current,
    input wire logic preexcite_done,
    input wire logic [2:0] other_out,
    output logic [15:0] freq_ref,
    output logic freq_override,
    output logic ramp_hold,
    output logic dc_inject,
    output logic output_block,
    output logic start_dc_dwell_off,
    output logic brake_release,
    output logic [2:0] relay
);
    mbs_pkg::mbs_seq_state_type q;
    mbs_pkg::mbs_seq_state_type d;
    logic tdone;
    logic [15:0] tlen;
    logic vec;
    logic torque;

    if (UNIT_CYCLES < 1) begin : g_check
        $error("mbs_brake_sequencer: UNIT_CYCLES must be at least one");
    end

    // Merges write data into a register under the byte enables.
    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Limits a written setting to its programmable range.
    function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] mx);
        return (v > mx) ? mx : v;
    endfunction

    function automatic logic is_vector(input logic [31:0] c);
        return c[`MBS_CTRL_MODE_LSB +: 3] == `MBS_MODE_VECTOR;
    endfunction

    assign vec = is_vector(q.ctrl);
    assign torque = q.ctrl[`MBS_CTRL_TORQUE_BIT];

    always_comb begin
        case (q.st)
            mbs_pkg::ST_REL_HOLD: tlen = q.release_cfg[31:16];
            mbs_pkg::ST_ENG_HOLD: tlen = q.engage[31:16];
            default: tlen = q.dc_stop[15:0];
        endcase
    end

    mbs_hold_timer #(
        .UNIT_CYCLES(UNIT_CYCLES),
        .LEN_W(16)
    ) u_timer (
        .mclk(mclk),
        .rst_n(rst_n),
        .start(q.tstart),
        .length(tlen),
        .done(tdone)
    );

    always_comb begin
        logic [31:0] m;
        logic dvec;
        logic tok;
        m = be_merge(32'h0000_0000, writedata, byteenable);
        dvec = 1'b0;
        tok = !q.tstart && tdone;
        d = q;
        d.tstart = 1'b0;
        // Bus: one wait cycle, then a single-cycle answer with waitrequest low.
        if ((read || write) && q.wait_req) begin
            d.wait_req = 1'b0;
            case (address)
                `MBS_OFS_CTRL: d.rdata = q.ctrl;
                `MBS_OFS_REL_FREQ: d.rdata = q.rel_freq;
                `MBS_OFS_ENGAGE: d.rdata = q.engage;
                `MBS_OFS_RELEASE: d.rdata = q.release_cfg;
                `MBS_OFS_DC_STOP: d.rdata = q.dc_stop;
                `MBS_OFS_STATUS: d.rdata = {25'h0, q.block, q.dc_inject, q.brake_release, 1'b0, q.st};
                default: d.rdata = 32'h0000_0000;
            endcase
        end else begin
            d.wait_req = 1'b1;
        end
        if (write && !q.wait_req) begin
            m = be_merge(32'h0000_0000, writedata, byteenable);
            case (address)
                `MBS_OFS_CTRL: d.ctrl = be_merge(q.ctrl, writedata, byteenable) & 32'h0000_071f;
                `MBS_OFS_REL_FREQ: begin
                    m = be_merge(q.rel_freq, writedata, byteenable);
                    d.rel_freq = {clamp(m[31:16], `MBS_FREQ_MAX), clamp(m[15:0], `MBS_FREQ_MAX)};
                end
                `MBS_OFS_ENGAGE: begin
                    m = be_merge(q.engage, writedata, byteenable);
                    d.engage = {clamp(m[31:16], `MBS_DELAY_MAX), clamp(m[15:0], `MBS_FREQ_MAX)};
                end
                `MBS_OFS_RELEASE: begin
                    m = be_merge(q.release_cfg, writedata, byteenable);
                    d.release_cfg = {clamp(m[31:16], `MBS_DELAY_MAX), clamp(m[15:0], `MBS_CURR_MAX)};
                end
                `MBS_OFS_DC_STOP: d.dc_stop = be_merge(q.dc_stop, writedata, byteenable);
                default: d.rdata = d.rdata;
            endcase
        end
        // Sequence steps.
        case (q.st)
            mbs_pkg::ST_IDLE: begin
                if (q.ctrl[`MBS_CTRL_EN_BIT] && run_cmd) begin
                    d.st = mbs_pkg::ST_WAIT_REL;
                    d.rev = reverse_cmd;
                end
            end
            mbs_pkg::ST_WAIT_REL: begin
                if (!run_cmd) begin
                    d.st = mbs_pkg::ST_IDLE;
                end else if (vec ? preexcite_done
                                 : (out_freq >= (q.rev ? q.rel_freq[31:16] : q.rel_freq[15:0])
                                    && motor_current >= q.release_cfg[15:0])) begin
                    d.st = mbs_pkg::ST_REL_HOLD;
                    d.tstart = 1'b1;
                end
            end
            mbs_pkg::ST_REL_HOLD: begin
                if (!run_cmd) begin
                    d.st = mbs_pkg::ST_DECEL;
                end else if (tok) begin
                    d.st = mbs_pkg::ST_RUN;
                end
            end
            mbs_pkg::ST_RUN: begin
                if (!run_cmd) begin
                    d.st = torque ? mbs_pkg::ST_IDLE : mbs_pkg::ST_DECEL;
                end
            end
            mbs_pkg::ST_DECEL: begin
                if (run_cmd) begin
                    d.st = mbs_pkg::ST_RUN;
                end else if (vec ? (out_freq == 16'h0000) : (out_freq <= q.engage[15:0])) begin
                    d.st = mbs_pkg::ST_ENG_HOLD;
                    d.tstart = 1'b1;
                end
            end
            mbs_pkg::ST_ENG_HOLD: begin
                if (tok) begin
                    if (!vec && q.dc_stop[15:0] != 16'h0000 && q.dc_stop[31:16] != 16'h0000) begin
                        d.st = mbs_pkg::ST_DC_INJ;
                        d.tstart = 1'b1;
                    end else begin
                        d.st = mbs_pkg::ST_IDLE;
                    end
                end
            end
            mbs_pkg::ST_DC_INJ: begin
                if (tok) begin
                    d.st = mbs_pkg::ST_IDLE;
                end
            end
            default: d.st = mbs_pkg::ST_IDLE;
        endcase
        if (!q.ctrl[`MBS_CTRL_EN_BIT]) begin
            d.st = mbs_pkg::ST_IDLE;
        end
        // Outputs follow the next state so they change together with it.
        dvec = is_vector(d.ctrl);
        d.suppress = d.ctrl[`MBS_CTRL_EN_BIT];
        d.override = 1'b1;
        d.hold = 1'b0;
        d.dc_inject = 1'b0;
        d.block = 1'b0;
        d.fref = 16'h0000;
        d.brake_release = 1'b0;
        case (d.st)
            mbs_pkg::ST_WAIT_REL: begin
                d.fref = dvec ? 16'h0000 : (d.rev ? d.rel_freq[31:16] : d.rel_freq[15:0]);
            end
            mbs_pkg::ST_REL_HOLD: begin
                d.fref = dvec ? 16'h0000 : (d.rev ? d.rel_freq[31:16] : d.rel_freq[15:0]);
                d.hold = 1'b1;
                d.brake_release = 1'b1;
            end
            mbs_pkg::ST_RUN, mbs_pkg::ST_DECEL: begin
                d.override = 1'b0;
                d.brake_release = 1'b1;
            end
            mbs_pkg::ST_ENG_HOLD: begin
                d.fref = dvec ? 16'h0000 : d.engage[15:0];
                d.hold = 1'b1;
            end
            mbs_pkg::ST_DC_INJ: begin
                d.dc_inject = 1'b1;
            end
            default: begin
                d.override = d.ctrl[`MBS_CTRL_EN_BIT];
                d.block = d.ctrl[`MBS_CTRL_EN_BIT];
            end
        endcase
        for (int i = 0; i < 3; i++) begin
            d.relay[i] = q.ctrl[`MBS_CTRL_SEL_LSB + i] ? d.brake_release : other_out[i];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            q <= '0;
            q.ctrl <= `MBS_RST_CTRL;
            q.rel_freq <= `MBS_RST_REL_FREQ;
            q.engage <= `MBS_RST_ENGAGE;
            q.release_cfg <= `MBS_RST_RELEASE;
            q.dc_stop <= `MBS_RST_DC_STOP;
            q.wait_req <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign readdata = q.rdata;
    assign waitrequest = q.wait_req;
    assign freq_ref = q.fref;
    assign freq_override = q.override;
    assign ramp_hold = q.hold;
    assign dc_inject = q.dc_inject;
    assign output_block = q.block;
    assign start_dc_dwell_off = q.suppress;
    assign brake_release = q.brake_release;
    assign relay = q.relay;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_suppress;
        (q.st != mbs_pkg::ST_IDLE) |-> q.suppress;
    endproperty
    a_suppress: assert property (p_suppress) else $error("start DC or dwell not suppressed");

    property p_rel_freq;
        (q.st == mbs_pkg::ST_WAIT_REL && !vec)
            |-> q.fref == (q.rev ? q.rel_freq[31:16] : q.rel_freq[15:0]);
    endproperty
    a_rel_freq: assert property (p_rel_freq) else $error("wrong release frequency");

    property p_rel_current;
        ($rose(q.brake_release) && !$past(vec)) |-> $past(motor_current >= q.release_cfg[15:0]);
    endproperty
    a_rel_current: assert property (p_rel_current) else $error("release below current");

    property p_rel_hold;
        $rose(q.brake_release) |-> q.st == mbs_pkg::ST_REL_HOLD && q.hold ##1 q.hold;
    endproperty
    a_rel_hold: assert property (p_rel_hold) else $error("release frequency not held");

    property p_engage_freq;
        ($fell(q.brake_release) && $past(q.st == mbs_pkg::ST_DECEL) && !$past(vec))
            |-> $past(out_freq <= q.engage[15:0]);
    endproperty
    a_engage_freq: assert property (p_engage_freq) else $error("engaged above frequency");

    property p_engage_zero;
        ($past(q.st == mbs_pkg::ST_ENG_HOLD) && q.st == mbs_pkg::ST_IDLE) |-> q.fref == 16'h0000;
    endproperty
    a_engage_zero: assert property (p_engage_zero) else $error("frequency not zero after hold");

    property p_dc_after;
        $rose(q.dc_inject) |-> $past(q.st == mbs_pkg::ST_ENG_HOLD) && !q.brake_release;
    endproperty
    a_dc_after: assert property (p_dc_after) else $error("DC injection out of order");

    property p_vec_release;
        (q.st == mbs_pkg::ST_WAIT_REL && vec && preexcite_done && run_cmd && q.ctrl[0])
            |=> q.brake_release;
    endproperty
    a_vec_release: assert property (p_vec_release) else $error("vector release late");

    property p_vec_delay;
        (q.st == mbs_pkg::ST_REL_HOLD && (q.tstart || !tdone)) |=> q.st != mbs_pkg::ST_RUN;
    endproperty
    a_vec_delay: assert property (p_vec_delay) else $error("acceleration before delay");

    property p_vec_engage;
        ($fell(q.brake_release) && $past(vec) && $past(q.st == mbs_pkg::ST_DECEL))
            |-> $past(out_freq) == 16'h0000;
    endproperty
    a_vec_engage: assert property (p_vec_engage) else $error("vector engage above 0 Hz");

    property p_torque;
        (q.st == mbs_pkg::ST_RUN && torque && !run_cmd) |=> q.st == mbs_pkg::ST_IDLE;
    endproperty
    a_torque: assert property (p_torque) else $error("engage sequence in torque mode");

    property p_relay_pass;
        !q.ctrl[`MBS_CTRL_SEL_LSB] |=> q.relay[0] == $past(other_out[0]);
    endproperty
    a_relay_pass: assert property (p_relay_pass) else $error("unselected output disturbed");

    property p_run_release;
        (q.st == mbs_pkg::ST_RUN || q.st == mbs_pkg::ST_DECEL) |-> q.brake_release;
    endproperty
    a_run_release: assert property (p_run_release) else $error("release dropped early");

    c_rel_seq: cover property (q.st == mbs_pkg::ST_REL_HOLD && !vec ##[1:300] q.st == mbs_pkg::ST_RUN);
    c_vec_seq: cover property ($fell(q.brake_release) && vec);
    c_dc_seq: cover property ($fell(q.dc_inject) && q.block);

endmodule // mbs_brake_sequencer

`default_nettype wire

// file: verif/mbs_drive_model.sv
// Drive model: ramps output frequency, reports motor current and pre-excitation.
// Assumes the sequencer outputs on mclk; the bench sets load current and pre-excitation length.
`timescale 1ns/10ps
`default_nettype none

module mbs_drive_model #(
    parameter int STEP = 25,
    parameter int RUN_SPEED = 1000
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic run_cmd,
    input wire logic [15:0] freq_ref,
    input wire logic freq_override,
    input wire logic ramp_hold,
    input wire logic output_block,
    input wire logic [15:0] cur_level,
    input wire logic [15:0] prex_len,
    output var logic [15:0] out_freq,
    output var logic [15:0] motor_current,
    output var logic preexcite_done
);
    logic [15:0] tgt;
    logic [15:0] prex_q;

    // A blocked output always coasts to zero; the sequencer wins over the run speed.
    assign tgt = output_block ? 16'h0000 : freq_override ? freq_ref
        : run_cmd ? 16'(RUN_SPEED) : 16'h0000;
    assign motor_current = (out_freq != 16'h0000 && !output_block) ? cur_level : 16'h0000;
    assign preexcite_done = run_cmd && prex_q >= prex_len;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            out_freq <= 16'h0000;
            prex_q <= 16'h0000;
        end else begin
            if (!run_cmd) begin
                prex_q <= 16'h0000;
            end else if (prex_q != 16'hffff) begin
                prex_q <= prex_q + 16'h0001;
            end
            // A ramp hold stops acceleration only; deceleration goes on.
            if (out_freq < tgt && !ramp_hold) begin
                out_freq <= (tgt - out_freq > STEP) ? out_freq + 16'(STEP) : tgt;
            end else if (out_freq > tgt) begin
                out_freq <= (out_freq - tgt > STEP) ? out_freq - 16'(STEP) : tgt;
            end
        end
    end
endmodule // mbs_drive_model
`default_nettype wire

// file: verif/test_mbs_brake_sequencer.sv
// Testbench of the brake sequencer: register bus, non-vector, vector and torque sequences.
// Assumes the drive model on the far side; UNIT_CYCLES is shortened to 4.
`timescale 1ns/10ps
`default_nettype none
`include "mbs_params.svh"

module test_mbs_brake_sequencer;
    localparam int UNIT = 4;
    localparam int BR = 0, OVR = 1, HOLD = 2, BLK = 3, DCI = 4, FRQ = 5;
    logic mclk, rst_n, read, write, waitrequest, run_cmd, reverse_cmd, preexcite_done;
    logic [`MBS_ADDR_W-1:0] address;
    logic [31:0] writedata, readdata;
    logic [3:0] byteenable;
    logic [15:0] out_freq, motor_current, freq_ref, cur_level, prex_len;
    logic [2:0] other_out, relay;
    logic freq_override, ramp_hold, dc_inject, output_block, start_dc_dwell_off, brake_release;
    int fail_count = 0;
    int checks_done = 0;
    int cyc = 0;

    mbs_brake_sequencer #(.UNIT_CYCLES(UNIT)) DUT (.mclk(mclk), .rst_n(rst_n),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .run_cmd(run_cmd), .reverse_cmd(reverse_cmd), .out_freq(out_freq),
        .motor_current(motor_current), .preexcite_done(preexcite_done), .other_out(other_out),
        .freq_ref(freq_ref), .freq_override(freq_override), .ramp_hold(ramp_hold),
        .dc_inject(dc_inject), .output_block(output_block),
        .start_dc_dwell_off(start_dc_dwell_off), .brake_release(brake_release), .relay(relay));

    mbs_drive_model u_drive (.mclk(mclk), .rst_n(rst_n), .run_cmd(run_cmd),
        .freq_ref(freq_ref), .freq_override(freq_override), .ramp_hold(ramp_hold),
        .output_block(output_block), .cur_level(cur_level), .prex_len(prex_len),
        .out_freq(out_freq), .motor_current(motor_current), .preexcite_done(preexcite_done));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Holds the request until waitrequest is sampled low, then takes the data.
    task automatic bus(input logic wr_en, input logic [4:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] q);
        int n;
        @(posedge mclk);
        address <= a;
        writedata <= d;
        byteenable <= be;
        write <= wr_en;
        read <= !wr_en;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
        if (n >= 50) begin
            chk(32'h0, 32'h1, "bus");
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] q;
        bus(1'b1, a, d, be, q);
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'hf, q);
        chk(q, exp, what);
    endtask

    function automatic logic hit(input int k, input logic [15:0] v);
        case (k)
            BR: return brake_release === v[0];
            OVR: return freq_override === v[0];
            HOLD: return ramp_hold === v[0];
            BLK: return output_block === v[0];
            DCI: return dc_inject === v[0];
            default: return out_freq === v;
        endcase
    endfunction

    task automatic wait_for(input int k, input logic [15:0] v, input int lim, output int n);
        n = 0;
        while (!hit(k, v) && n < lim) begin
            @(posedge mclk);
            n++;
        end
        if (n >= lim) begin
            chk(32'h0, 32'h1, "wait");
        end
    endtask

    // Run from stop with the load current first below and then above the threshold.
    task automatic nv_release(input logic [15:0] rf);
        int n;
        repeat (20) @(posedge mclk);
        run_cmd <= 1'b1;
        cur_level <= 16'd300;
        wait_for(FRQ, rf, 200, n);
        chk(freq_ref, rf, "release freq");
        repeat (10) @(posedge mclk);
        chk(brake_release, 1'b0, "early release");
        chk(start_dc_dwell_off, 1'b1, "dwell off");
        cur_level <= 16'd500;
        wait_for(BR, 16'h1, 20, n);
        chk(ramp_hold, 1'b1, "release hold");
        wait_for(OVR, 16'h0, 50, n);
        chk(n >= UNIT && n <= UNIT + 6, 1'b1, "release delay");
        chk(out_freq, rf, "held freq");
        chk(relay, {1'b1, other_out[1], 1'b1}, "relay on");
        wait_for(FRQ, 16'd1000, 200, n);
    endtask

    task automatic nv_stop(input logic dc);
        int n;
        run_cmd <= 1'b0;
        wait_for(BR, 16'h0, 200, n);
        chk(out_freq <= 16'd200, 1'b1, "engage point");
        chk(freq_ref, 16'd200, "engage freq");
        chk(ramp_hold, 1'b1, "engage hold");
        if (dc) begin
            wait_for(DCI, 16'h1, 50, n);
            chk(n >= UNIT && n <= UNIT + 6, 1'b1, "dc start");
            chk(output_block, 1'b0, "dc block");
        end
        wait_for(BLK, 16'h1, 50, n);
        chk(n >= UNIT && n <= UNIT + 6, 1'b1, "engage delay");
        chk(freq_ref, 16'h0, "zero freq");
        chk(relay, {1'b0, other_out[1], 1'b0}, "relay off");
    endtask

    initial begin
        int n;
        logic [31:0] q;
        int modes[7];
        modes = '{0, 1, 2, 3, 4, 6, 7};
        rst_n = 1'b0;
        address = '0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        byteenable = 4'h0;
        run_cmd = 1'b0;
        reverse_cmd = 1'b0;
        other_out = 3'b010;
        cur_level = 16'h0;
        prex_len = 16'hffff;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        rd(`MBS_OFS_CTRL, `MBS_RST_CTRL, "ctrl reset");
        rd(`MBS_OFS_REL_FREQ, `MBS_RST_REL_FREQ, "rel reset");
        rd(`MBS_OFS_ENGAGE, `MBS_RST_ENGAGE, "engage reset");
        rd(`MBS_OFS_RELEASE, `MBS_RST_RELEASE, "release reset");
        rd(`MBS_OFS_DC_STOP, `MBS_RST_DC_STOP, "dc reset");
        rd(5'h18, 32'h0, "unmapped");
        rd(5'h01, 32'h0, "unaligned");
        wr(`MBS_OFS_RELEASE, 32'h0000_ffff, 4'hf);
        rd(`MBS_OFS_RELEASE, 32'h0000_0708, "clamp");
        wr(`MBS_OFS_REL_FREQ, 32'h00c8_ffff, 4'hc);
        rd(`MBS_OFS_REL_FREQ, 32'h00c8_0064, "lanes");
        wr(`MBS_OFS_RELEASE, 32'h0001_0190, 4'hf);
        wr(`MBS_OFS_ENGAGE, 32'h0001_00c8, 4'hf);
        wr(`MBS_OFS_STATUS, 32'hffff_ffff, 4'hf);
        rd(`MBS_OFS_STATUS, 32'h0, "status ro");
        // Brake control off: nothing runs; the selected relays still show the low brake release, relay[1] its own function.
        wr(`MBS_OFS_CTRL, 32'h0000_0500, 4'hf);
        run_cmd <= 1'b1;
        cur_level <= 16'd500;
        repeat (30) @(posedge mclk);
        chk({brake_release, freq_override, output_block, start_dc_dwell_off}, 4'h0, "disabled");
        chk(relay, other_out, "relay pass");
        run_cmd <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            wr(`MBS_OFS_CTRL, 32'h0000_0501 | (32'(modes[i]) << 1), 4'hf);
            nv_release(16'd100);
            nv_stop(1'b0);
        end
        other_out <= 3'b101;
        reverse_cmd <= 1'b1;
        wr(`MBS_OFS_DC_STOP, 32'h0005_0001, 4'hf);
        nv_release(16'd200);
        nv_stop(1'b1);
        reverse_cmd <= 1'b0;
        wr(`MBS_OFS_DC_STOP, 32'h0, 4'hf);
        // Vector mode: release on pre-excitation only, zero speed until the delay passes.
        wr(`MBS_OFS_CTRL, 32'h0000_050b, 4'hf);
        prex_len <= 16'd20;
        repeat (20) @(posedge mclk);
        run_cmd <= 1'b1;
        cur_level <= 16'd0;
        wait_for(BR, 16'h1, 100, n);
        chk(n >= 20 && n <= 24, 1'b1, "prex wait");
        chk(preexcite_done, 1'b1, "prex done");
        wait_for(HOLD, 16'h0, 50, n);
        chk(n >= UNIT && n <= UNIT + 6, 1'b1, "vector delay");
        chk(out_freq, 16'h0, "no accel");
        cur_level <= 16'd500;
        wait_for(FRQ, 16'd1000, 200, n);
        run_cmd <= 1'b0;
        wait_for(BR, 16'h0, 200, n);
        chk(out_freq, 16'h0, "vector engage");
        wait_for(BLK, 16'h1, 50, n);
        chk(n >= UNIT && n <= UNIT + 6, 1'b1, "vector cut");
        // Torque mode: a stop from run skips the engage sequence.
        wr(`MBS_OFS_CTRL, 32'h0000_0411, 4'hf);
        prex_len <= 16'hffff;
        nv_release(16'd100);
        run_cmd <= 1'b0;
        repeat (3) @(posedge mclk);
        chk({brake_release, ramp_hold}, 2'b00, "torque stop");
        chk(relay, {1'b0, other_out[1:0]}, "unselected relay");
        bus(1'b0, `MBS_OFS_STATUS, 32'h0, 4'hf, q);
        chk(q[2:0], 3'h0, "torque idle");
        finish_test();
    end
endmodule // test_mbs_brake_sequencer
`default_nettype wire
